// *** rtl/alarm_monitor.sv ***
/*
 * Alarm monitor of a converter's serial-link transmitter, with AXI4-Lite registers.
 * Assumes pins and clock compare inputs are asynchronous and are synchronised here;
 * the clock compare inputs are sampled on the half-rate device clock domain = clock.
 */
// Function
// - each of six alarm sources has its own status bit.
// - a set alarm bit stays set until the host writes a one to it.
// - the summary alarm reflects only alarms not disabled in the mask.
// - with alarm output selected the status pin goes high on any alarm not disabled in the mask.
// - any single-cycle mismatch between channel A and B clocks, with neither channel powered down, sets the clock upset flag.
// - the clock upset flag stays set until the host writes a one to it.
// - after leaving global power-down the host clears a clock upset flag left set.
// - each lane has a FIFO upset flag set to one on a pointer upset.
// - driving link enable low then high resets the synchronizing FIFO logic.
// - SYSREF resets the multiframe counter (8b10b) or extended multiblock counter (64b66b).
// - without SYSREF the counter free-runs and SYNC still starts sync and ILAS in 8b10b.
// - while link enable is low the link is held in reset, serializers down, clocks gated.
`include "alarm_monitor_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module alarm_monitor #(
    parameter int LANES = 8
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // AXI4-Lite slave
    input  wire logic [11:0]      awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output alarm_monitor_pkg::axi_resp_t bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [11:0]      araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output alarm_monitor_pkg::axi_resp_t rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    // alarm sources (asynchronous)
    input  wire logic             convPllLocked,
    input  wire logic             serPllLocked,
    input  wire logic             sysrefIn,
    input  wire logic             syncRequest,
    input  wire logic             clockPhaseA,
    input  wire logic             clockPhaseB,
    input  wire logic [LANES-1:0] fifoPointerUpset,
    // link controls and pins
    output logic                  linkReset,
    output logic                  serializerPowerDown,
    output logic                  linkClockGate,
    output logic                  fifoReset,
    output logic                  multiframeEdge,
    output logic                  startSyncIlas,
    output logic                  cal_status_pin,
    output logic                  irq
);
    import alarm_monitor_pkg::*;

    localparam int NS = `ALARM_COUNT;

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    localparam int SW = 6 + LANES;
    logic [SW-1:0] syncMeta;
    logic [SW-1:0] syncOut;

    // two flops on every asynchronous input; only syncOut is read further on
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            syncMeta <= '0;
            syncOut  <= '0;
        end else begin
            syncMeta <= {fifoPointerUpset, clockPhaseB, clockPhaseA, syncRequest, sysrefIn,
                         serPllLocked, convPllLocked};
            syncOut  <= syncMeta;
        end
    end

    logic             convLock;
    logic             serLock;
    logic             sysrefS;
    logic             syncS;
    logic             phaseA;
    logic             phaseB;
    logic [LANES-1:0] laneUpset;
    assign convLock  = syncOut[0];
    assign serLock   = syncOut[1];
    assign sysrefS   = syncOut[2];
    assign syncS     = syncOut[3];
    assign phaseA    = syncOut[4];
    assign phaseB    = syncOut[5];
    assign laneUpset = syncOut[SW-1:6];

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------
    logic [NS-1:0]    alarm_status_bits;
    logic [NS-1:0]    alarm_mask;
    logic [5:0]       control;
    logic [LANES-1:0] lane_fifo_upset_flags;
    logic [1:0]       irqStatus;
    logic [1:0]       irqMask;
    link_state_t      linkState;

    logic link_enable;
    logic power_down_channel_a;
    logic power_down_channel_b;
    logic statusSel;
    assign link_enable          = control[`CTL_LINK_ENABLE];
    assign power_down_channel_a = control[`CTL_PD_CH_A];
    assign power_down_channel_b = control[`CTL_PD_CH_B];
    assign statusSel            = control[`CTL_STATUS_SEL];

    // write side: address and data are latched independently, in either order
    logic        awHeld;
    logic        wHeld;
    logic [11:0] wAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        doWrite;
    assign doWrite = awHeld && wHeld && !bvalid;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            wAddr  <= 12'h000;
            wData  <= 32'h00000000;
            wStrb  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                wAddr  <= awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wData <= wdata;
                wStrb <= wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // ready only while the holding slot is empty
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= !(awvalid && awready) && !awHeld;
            wready  <= !(wvalid && wready) && !wHeld;
        end
    end

    function automatic logic known(input logic [11:0] a);
        unique case (a)
            `OFS_ALARM_STATUS, `OFS_ALARM_MASK, `OFS_ALARM_SUMMARY, `OFS_CONTROL,
            `OFS_LANE_FIFO, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_LINK_STATE: known = 1'b1;
            default: known = 1'b0;
        endcase
    endfunction

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= known(wAddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    logic wrStatus;
    logic wrLane;
    assign wrStatus = doWrite && wAddr == `OFS_ALARM_STATUS && wStrb[0];
    assign wrLane   = doWrite && wAddr == `OFS_LANE_FIFO && wStrb[0];

    // plain read/write configuration
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            alarm_mask <= `RST_ALARM_MASK;
            control    <= `RST_CONTROL;
            irqMask    <= `RST_IRQ_MASK;
        end else if (doWrite && wStrb[0]) begin
            if (wAddr == `OFS_ALARM_MASK)
                alarm_mask <= wData[NS-1:0];
            if (wAddr == `OFS_CONTROL)
                control <= wData[5:0];
            if (wAddr == `OFS_IRQ_MASK)
                irqMask <= wData[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // link enable handling
    // ------------------------------------------------------------------------
    // holding the link in reset also gates its clocks and powers serializers down
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            linkReset           <= 1'b1;
            serializerPowerDown <= 1'b1;
            linkClockGate       <= 1'b0;
            fifoReset           <= 1'b1;
        end else begin
            linkReset           <= !link_enable;
            serializerPowerDown <= !link_enable;
            linkClockGate       <= link_enable;
            fifoReset           <= !link_enable;
        end
    end

    // ------------------------------------------------------------------------
    // multiframe counter and link state
    // ------------------------------------------------------------------------
    logic       sysrefQ;
    logic [7:0] mfCount;
    logic [7:0] mfPeriod;
    logic       sysrefRise;
    assign mfPeriod   = control[`CTL_ENCODING_64] ? `MF_PERIOD_64B66B : `MF_PERIOD_8B10B;
    assign sysrefRise = sysrefS && !sysrefQ && control[`CTL_SUBCLASS1];

    // free-running in subclass 0, so phase is arbitrary there
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sysrefQ        <= 1'b0;
            mfCount        <= 8'h00;
            multiframeEdge <= 1'b0;
        end else begin
            sysrefQ <= sysrefS;
            if (!link_enable || sysrefRise)
                mfCount <= 8'h00;
            else if (mfCount >= mfPeriod - 8'h01) // a change to 8b10b with the count past its period wraps at once
                mfCount <= 8'h00;
            else
                mfCount <= mfCount + 8'h01;
            multiframeEdge <= link_enable && mfCount == 8'h00;
        end
    end

    // sync request starts code group sync then ILAS only in 8b10b; 64b66b goes to data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            linkState     <= LINK_OFF;
            startSyncIlas <= 1'b0;
        end else begin
            startSyncIlas <= 1'b0;
            unique case (linkState)
                LINK_OFF:
                    if (link_enable) linkState <= LINK_SYNC;
                LINK_SYNC:
                    if (!link_enable) linkState <= LINK_OFF;
                    else if (control[`CTL_ENCODING_64] || !syncS) linkState <= LINK_DATA;
                    else startSyncIlas <= 1'b1;
                LINK_DATA:
                    if (!link_enable) linkState <= LINK_OFF;
                    else if (!control[`CTL_ENCODING_64] && syncS) linkState <= LINK_SYNC;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // alarm events and sticky status
    // ------------------------------------------------------------------------
    logic [NS-1:0] event_;
    logic          clockMismatch;
    // compare only when both channels run; a powered-down side would always differ
    assign clockMismatch = (phaseA != phaseB) && !power_down_channel_a
                           && !power_down_channel_b;

    always_comb begin
        event_ = '0;
        event_[`BIT_CONV_PLL]      = !convLock;
        event_[`BIT_SER_PLL]       = !serLock;
        event_[`BIT_LINK_NOT_DATA] = linkState != LINK_DATA;
        event_[`BIT_SYSREF_ALIGN]  = sysrefRise && mfCount != 8'h00;
        event_[`BIT_CLOCK_UPSET]   = clockMismatch;
        event_[`BIT_FIFO_ERROR]    = |lane_fifo_upset_flags;
    end

    // write one to clear; a same-cycle event keeps the bit set
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            alarm_status_bits <= '0;
        else
            alarm_status_bits <= (alarm_status_bits & ~(wrStatus ? wData[NS-1:0] : '0))
                                 | event_;
    end

    // lane flags are held in reset while the link is disabled
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            lane_fifo_upset_flags <= '0;
        else if (!link_enable)
            lane_fifo_upset_flags <= '0;
        else
            lane_fifo_upset_flags <= (lane_fifo_upset_flags & ~(wrLane ? wData[LANES-1:0] : '0))
                                     | laneUpset;
    end

    logic summary;
    assign summary = |(alarm_status_bits & ~alarm_mask);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            cal_status_pin <= 1'b0;
        else
            cal_status_pin <= statusSel && summary;
    end

    // ------------------------------------------------------------------------
    // interrupt: bit0 summary rise, bit1 clock upset rise; read clears
    // ------------------------------------------------------------------------
    logic summaryQ;
    logic upsetQ;
    logic rdIrq;
    logic [1:0] irqEvent;
    assign irqEvent = {alarm_status_bits[`BIT_CLOCK_UPSET] && !upsetQ, summary && !summaryQ};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            summaryQ  <= 1'b0;
            upsetQ    <= 1'b0;
            irqStatus <= 2'h0;
            irq       <= 1'b0;
        end else begin
            summaryQ  <= summary;
            upsetQ    <= alarm_status_bits[`BIT_CLOCK_UPSET];
            irqStatus <= (rdIrq ? 2'h0 : irqStatus) | irqEvent;
            irq       <= |(irqStatus & irqMask);
        end
    end

    // ------------------------------------------------------------------------
    // read side: one cycle after the address is taken
    // ------------------------------------------------------------------------
    assign rdIrq = arvalid && arready && araddr == `OFS_IRQ_STATUS;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp  <= known(araddr) ? RESP_OKAY : RESP_SLVERR;
                unique case (araddr)
                    `OFS_ALARM_STATUS:  rdata <= 32'(alarm_status_bits);
                    `OFS_ALARM_MASK:    rdata <= 32'(alarm_mask);
                    `OFS_ALARM_SUMMARY: rdata <= 32'(summary);
                    `OFS_CONTROL:       rdata <= 32'(control);
                    `OFS_LANE_FIFO:     rdata <= 32'(lane_fifo_upset_flags);
                    `OFS_IRQ_STATUS:    rdata <= 32'(irqStatus);
                    `OFS_IRQ_MASK:      rdata <= 32'(irqMask);
                    `OFS_LINK_STATE:    rdata <= 32'(linkState);
                    default:            rdata <= 32'h00000000;
                endcase
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** shared/alarm_monitor_consts.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the alarm monitor.
 * Assumes it is included by bare name from files that need the constants.
 */
`ifndef ALARM_MONITOR_CONSTS_SVH
`define ALARM_MONITOR_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_ALARM_STATUS   12'h000
`define OFS_ALARM_MASK     12'h004
`define OFS_ALARM_SUMMARY  12'h008
`define OFS_CONTROL        12'h00C
`define OFS_LANE_FIFO      12'h010
`define OFS_IRQ_STATUS     12'h014
`define OFS_IRQ_MASK       12'h018
`define OFS_LINK_STATE     12'h01C

// ----------------------------------------------------------------------------
// alarm status bit positions
// ----------------------------------------------------------------------------
`define BIT_CONV_PLL       0
`define BIT_SER_PLL        1
`define BIT_LINK_NOT_DATA  2
`define BIT_SYSREF_ALIGN   3
`define BIT_CLOCK_UPSET    4
`define BIT_FIFO_ERROR     5
`define ALARM_COUNT        6

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CTL_LINK_ENABLE    0
`define CTL_PD_CH_A        1
`define CTL_PD_CH_B        2
`define CTL_STATUS_SEL     3
`define CTL_ENCODING_64    4
`define CTL_SUBCLASS1      5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_ALARM_MASK     6'h3F
`define RST_CONTROL        6'h20
`define RST_IRQ_MASK       2'h0

// ----------------------------------------------------------------------------
// multiframe counter length in half-rate clock cycles
// ----------------------------------------------------------------------------
`define MF_PERIOD_8B10B    8'h20
`define MF_PERIOD_64B66B   8'h80

`endif

// *** shared/alarm_monitor_pkg.sv ***
/*
 * Types of the alarm monitor.
 * Assumes nothing of its surroundings.
 */
package alarm_monitor_pkg;
    typedef enum logic [2:0] {
        LINK_OFF  = 3'b001,
        LINK_SYNC = 3'b010,
        LINK_DATA = 3'b100
    } link_state_t;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;
endpackage

// *** sim/alarm_monitor_chk.sv ***
/*
 * Checker of the alarm monitor's bus handshakes and link control outputs.
 * Assumes it is bound to alarm_monitor and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module alarm_monitor_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // link controls
    input wire logic        linkReset,
    input wire logic        serializerPowerDown,
    input wire logic        linkClockGate,
    input wire logic        fifoReset,
    input wire logic        multiframeEdge,
    input wire logic        startSyncIlas
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // ------------------------------------
    // bus answers
    // ------------------------------------
    // address and data offered together, taken on one edge
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    wr_answer_a: assert property (wr_taken |-> ##2 bvalid)
        else $error("write answer not two cycles after acceptance");
    wr_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped before taken");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer not one cycle after acceptance");
    rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer changed before taken");
    rd_block_a: assert property (rvalid |-> !arready)
        else $error("read address accepted while answer pending");

    // ------------------------------------
    // link controls
    // ------------------------------------
    link_off_a: assert property (linkReset |-> serializerPowerDown && !linkClockGate)
        else $error("link held in reset with serializers or clocks on");
    fifo_reset_a: assert property (fifoReset == linkReset)
        else $error("fifo reset does not follow link enable");
    frame_pulse_a: assert property (multiframeEdge |=> !multiframeEdge)
        else $error("multiframe edge longer than one cycle");
    sync_live_a: assert property (startSyncIlas |-> !linkReset)
        else $error("sync start while link held in reset");
endmodule

bind alarm_monitor alarm_monitor_chk u_chk (.clock, .nrst, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .linkReset,
    .serializerPowerDown, .linkClockGate, .fifoReset, .multiframeEdge, .startSyncIlas);

`default_nettype wire

// *** sim/tb.sv ***
/*
 * Self-checking bench of the alarm monitor; a status model is kept in expStat.
 * Assumes the design's hand-over timing: inputs reach status within 4 edges.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alarm_monitor_consts.svh"

module tb;
    import alarm_monitor_pkg::*;
    logic        clock = 0, nrst = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, v, expStat;
    logic [3:0]  wstrb = 4'hF;
    logic        convPllLocked = 1, serPllLocked = 1, sysrefIn = 0, syncRequest = 0;
    logic        clockPhaseA = 0, clockPhaseB = 0;
    logic [7:0]  fifoPointerUpset = '0;
    logic        awready, wready, arready, bvalid, rvalid, linkReset, serializerPowerDown;
    logic        linkClockGate, fifoReset, multiframeEdge, startSyncIlas, cal_status_pin, irq;
    logic [31:0] rdata;
    axi_resp_t   bresp, rresp;
    int          fail_count = 0, check_count = 0, n, lane;
    int          srcBit[4] = '{0, 1, 4, 5};

    always #50 clock = ~clock;

    alarm_monitor #(.LANES(8)) dut (.clock, .nrst, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .convPllLocked, .serPllLocked, .sysrefIn,
        .syncRequest, .clockPhaseA, .clockPhaseB, .fifoPointerUpset, .linkReset,
        .serializerPowerDown, .linkClockGate, .fifoReset, .multiframeEdge, .startSyncIlas,
        .cal_status_pin, .irq);

    // ------------------------------------
    // shared tasks
    // ------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask

    // ready is late on purpose so the slave must hold its answer
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input axi_resp_t er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        fork
            begin do @(posedge clock); while (!awready); awvalid <= 0; end
            begin do @(posedge clock); while (!wready); wvalid <= 0; end
        join
        cyc(2);
        bready <= 1;
        do @(posedge clock); while (!bvalid);
        bready <= 0;
        check(32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [11:0] a, input axi_resp_t er);
        araddr <= a;
        arvalid <= 1;
        do @(posedge clock); while (!arready);
        arvalid <= 0;
        @(posedge clock);
        rready <= 1;
        do @(posedge clock); while (!rvalid);
        rready <= 0;
        v = rdata;
        check(32'(rresp), 32'(er));
    endtask

    task automatic chk_stat;
        rd(`OFS_ALARM_STATUS, RESP_OKAY);
        check(v & 32'h3B, expStat);
    endtask

    // counts cycles up to the next multiframe pulse
    task automatic wait_edge;
        n = 0;
        do begin @(posedge clock); n++; end while (multiframeEdge !== 1'b1);
    endtask

    // ------------------------------------
    // tests
    // ------------------------------------
    initial begin
        v = $urandom(32'h5B2B);
        cyc(3);
        nrst <= 1;
        cyc(2);
        check(32'({linkReset, serializerPowerDown, fifoReset, linkClockGate}), 32'hE);
        rd(`OFS_ALARM_MASK, RESP_OKAY);
        check(v, 32'(`RST_ALARM_MASK));
        rd(`OFS_CONTROL, RESP_OKAY);
        check(v, 32'(`RST_CONTROL));
        rd(`OFS_LINK_STATE, RESP_OKAY);
        check(v, 32'(LINK_OFF));
        wr(12'h040, $urandom, RESP_SLVERR);
        rd(12'h040, RESP_SLVERR);
        check(v, 32'h0);
        $display("test reset_and_map done");
        // power both channels, enable, then clear stale alarms
        wr(`OFS_CONTROL, 32'h21, RESP_OKAY);
        cyc(3);
        check(32'({linkReset, serializerPowerDown, fifoReset, linkClockGate}), 32'h1);
        wr(`OFS_ALARM_STATUS, 32'h3F, RESP_OKAY);
        expStat = 32'h0;
        chk_stat();
        for (int k = 0; k < 4; k++) begin
            lane = $urandom_range(7);
            convPllLocked <= (k != 0);
            serPllLocked <= (k != 1);
            clockPhaseB <= (k == 2);
            fifoPointerUpset <= (k == 3) ? 8'(1 << lane) : 8'h0;
            @(posedge clock);
            {convPllLocked, serPllLocked, clockPhaseB, fifoPointerUpset} <= 11'h600;
            cyc(4);
            expStat = 32'(1 << srcBit[k]);
            chk_stat();
            if (k == 3) begin
                rd(`OFS_LANE_FIFO, RESP_OKAY);
                check(v, 32'(1 << lane));
                wr(`OFS_LANE_FIFO, 32'(1 << lane), RESP_OKAY);
            end
            wr(`OFS_ALARM_STATUS, expStat, RESP_OKAY);
            expStat = 32'h0;
            chk_stat();
        end
        $display("test sources done");
        wr(`OFS_IRQ_MASK, 32'h1, RESP_OKAY);
        wr(`OFS_CONTROL, 32'h29, RESP_OKAY);
        convPllLocked <= 0;
        cyc(4);
        wr(`OFS_ALARM_STATUS, 32'h1, RESP_OKAY);
        expStat = 32'h1;
        chk_stat();
        rd(`OFS_ALARM_SUMMARY, RESP_OKAY);
        check(v, 32'h0);
        check(32'(cal_status_pin), 32'h0);
        wr(`OFS_ALARM_MASK, 32'h3E, RESP_OKAY);
        cyc(3);
        rd(`OFS_ALARM_SUMMARY, RESP_OKAY);
        check(v, 32'h1);
        check(32'({cal_status_pin, irq}), 32'h3);
        rd(`OFS_IRQ_STATUS, RESP_OKAY);
        check(v & 32'h1, 32'h1);
        cyc(2);
        check(32'(irq), 32'h0);
        wr(`OFS_CONTROL, 32'h21, RESP_OKAY);
        cyc(2);
        check(32'(cal_status_pin), 32'h0);
        convPllLocked <= 1;
        cyc(4);
        wr(`OFS_ALARM_STATUS, 32'h1, RESP_OKAY);
        expStat = 32'h0;
        chk_stat();
        $display("test mask_pin_irq done");
        fifoPointerUpset <= 8'h80;
        @(posedge clock);
        fifoPointerUpset <= 8'h0;
        cyc(4);
        rd(`OFS_LANE_FIFO, RESP_OKAY);
        check(v, 32'h80);
        wr(`OFS_CONTROL, 32'h20, RESP_OKAY);
        cyc(2);
        check(32'({linkReset, serializerPowerDown, fifoReset, linkClockGate}), 32'hE);
        rd(`OFS_LANE_FIFO, RESP_OKAY);
        check(v, 32'h0);
        wr(`OFS_CONTROL, 32'h21, RESP_OKAY);
        wr(`OFS_ALARM_STATUS, 32'h20, RESP_OKAY);
        syncRequest <= 1;
        cyc(5);
        check(32'(startSyncIlas), 32'h1);
        rd(`OFS_LINK_STATE, RESP_OKAY);
        check(v, 32'(LINK_SYNC));
        syncRequest <= 0;
        $display("test link_toggle_sync done");
        for (int m = 0; m < 2; m++) begin
            wr(`OFS_CONTROL, m ? 32'h31 : 32'h21, RESP_OKAY);
            wait_edge();
            wait_edge();
            check(n, m ? `MF_PERIOD_64B66B : `MF_PERIOD_8B10B);
        end
        wr(`OFS_CONTROL, 32'h21, RESP_OKAY);
        wait_edge();
        cyc(10);
        sysrefIn <= 1;
        wait_edge();
        check(32'(n < 8), 32'h1);
        sysrefIn <= 0;
        cyc(4);
        expStat = 32'h8;
        chk_stat();
        $display("test frame_counter done");
        give_verdict();
    end

    // hang guard, far beyond the several hundred cycles the tests need
    initial begin
        cyc(20000);
        fail_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
